// file: rtl/pms_pkg.sv
package pms_pkg;
	// Modulation level field encodings
	localparam logic [1:0] LEVEL_2 = 2'h0;
	localparam logic [1:0] LEVEL_4 = 2'h1;
	localparam logic [1:0] LEVEL_8 = 2'h2;
	localparam logic [1:0] LEVEL_16 = 2'h3;
	// Ramp select field encodings
	localparam logic [1:0] RAMP_OFF = 2'h0;
	localparam logic [1:0] RAMP_P23 = 2'h1;
	localparam logic [1:0] RAMP_P3 = 2'h2;
	localparam logic [1:0] RAMP_SERIAL = 2'h3;
	// Parameter select field encodings
	localparam logic [1:0] PARAM_NONE = 2'h0;
	localparam logic [1:0] PARAM_AMPL = 2'h1;
	localparam logic [1:0] PARAM_FREQ = 2'h2;
	localparam logic [1:0] PARAM_PHASE = 2'h3;
	// Pin configuration encodings
	localparam logic [2:0] PINCFG_000 = 3'h0;
	localparam logic [2:0] PINCFG_011 = 3'h3;
	localparam logic [1:0] PINCFG_X01 = 2'h1;
	// Register addresses
	localparam logic [7:0] ADDR_FREQ0 = 8'h04;
	localparam logic [7:0] ADDR_PHASE0 = 8'h05;
	localparam logic [7:0] ADDR_AMPL0 = 8'h06;
	localparam logic [7:0] ADDR_PROFILE1 = 8'h0a;
	// Sweep end word resolutions
	localparam int FREQ_BITS = 32;
	localparam int PHASE_BITS = 14;
	localparam int AMPL_BITS = 10;
	// Reset values
	localparam logic [3:0] PROFILE_RESET = 4'h0;
	localparam logic [7:0] ADDR_RESET = 8'h04;
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_KEYING = 2'b01,
		MODE_SWEEP = 2'b11,
		MODE_BAD = 2'b10
	} pms_mode_type;
endpackage

// file: rtl/pms_pin_sync.sv
`timescale 1ns/1ps
module pms_pin_sync #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	logic [WIDTH-1:0] meta_reg;

	initial begin
		if (WIDTH < 1)
			$error("pms_pin_sync: WIDTH must be at least 1");
	end

	// Two stages so metastability settles before any decode
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_reg <= '0;
			pin_out <= '0;
		end else begin
			meta_reg <= pin_in;
			pin_out <= meta_reg;
		end
	end
endmodule

// file: rtl/pms_profile_select.sv
`timescale 1ns/1ps
// Overview of operation
// (R1) Level field 00/01/10/11 means 2/4/8/16 levels; keying needs sweep off and a nonzero parameter field.
// (R2) Two-level unramped: pin 1 picks profile 0 (0x04) or 1 (0x0A).
// (R3) Four-level unramped, config 011: pins 0,1 pick profile; 11 gives 0x0C.
// (R4) Eight-level unramped, config x01: pins 0..2 pick profile; 111 gives 0x10.
// (R5) Sixteen-level unramped, config x01: pins 0..3 pick; 1110 gives 0x17.
// (R6) Ramp 01: two-level only; 000 pin1 mod pin3 ramp; 011 pin0 mod pin2.
// (R7) Ramp 10: eight-level only; pins 0..2 select, pin 3 ramps.
// (R8) Ramp 11: serial pins 1..3 ramp; 2/4/16 levels; serial port single-bit.
// (R9) Four-level serial ramp: 000 pins 2,3 with serial 2; 011 pins 0,1 serial 1.
// (R10) Sixteen-level serial ramp, x01: pins 0..3 select; serial 1 ramps; 1101 is 0x16.
// (R11) Sweep start from profile 0 register by parameter; end from profile 1.
// (R12) End word 32/14/10 bits for frequency/phase/amplitude, MSB-aligned.
// (R13) During sweep profile pin 1 starts the sweep and sets its direction.
// (R14) Sweep needs enable 1, level 00; parameter 01/10/11 amplitude/frequency/phase.
// (R15) Controller enables sync clock and disables auxiliary cores before sweeping.
// (R16) Amplitude ramp through 10-bit scaler, controlled from profile or serial pins.
// (R17) Ramp pin low requests ramp up, high requests ramp down.
// (R18) Parameter field: 00 off, 01 amplitude, 10 frequency, 11 phase.
// (R19) Pins sampled on sync clock; new profile applied on the next cycle. Here profile_index changes on the third clk edge after a pin change.
module pms_profile_select (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration
	input wire logic [1:0] param_select_field,
	input wire logic [1:0] level_field,
	input wire logic [1:0] amplitude_ramp_field,
	input wire logic [2:0] pin_config_field,
	input wire logic sweep_enable,
	// Pins
	input wire logic profile_pin_0,
	input wire logic profile_pin_1,
	input wire logic profile_pin_2,
	input wire logic profile_pin_3,
	input wire logic serial_pin_1,
	input wire logic serial_pin_2,
	input wire logic serial_pin_3,
	// Profile selection
	output logic [3:0] profile_index,
	output logic [7:0] profile_addr,
	output logic modulation_active,
	output logic config_error,
	output logic serial_single_bit,
	// Sweep control
	output logic sweep_active,
	output logic sweep_up,
	output logic sweep_start,
	output logic [7:0] sweep_start_addr,
	output logic [7:0] sweep_end_addr,
	output logic [5:0] sweep_end_bits,
	// Amplitude ramp control
	output logic ramp_enable,
	output logic ramp_down
);
	logic [6:0] pins_raw;
	logic [6:0] pins;
	logic [3:0] p;
	logic [3:0] idx_next;
	logic ramp_en_next;
	logic ramp_dn_next;
	logic bad_next;
	logic pin1_last_reg;
	pms_pkg::pms_mode_type mode;

	assign pins_raw = {serial_pin_3, serial_pin_2, serial_pin_1,
		profile_pin_3, profile_pin_2, profile_pin_1, profile_pin_0};

	pms_pin_sync #(.WIDTH(7)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.pin_in(pins_raw), // R19
		.pin_out(pins)
	);

	assign p = pins[3:0];

	// Profile register address: 0 at 0x04, then 1..15 from 0x0A upward
	function automatic logic [7:0] addr_of(input logic [3:0] idx);
		if (idx == 4'h0)
			addr_of = pms_pkg::ADDR_FREQ0;
		else
			addr_of = pms_pkg::ADDR_PROFILE1 + {4'h0, idx} - 8'h01;
	endfunction

	function automatic logic cfg_x01(input logic [2:0] c);
		cfg_x01 = (c[1:0] == pms_pkg::PINCFG_X01);
	endfunction

	// Mode from the parameter, level and sweep fields
	always_comb begin
		if (sweep_enable) begin
			if (param_select_field != pms_pkg::PARAM_NONE &&
				level_field == pms_pkg::LEVEL_2) // R14
				mode = pms_pkg::MODE_SWEEP;
			else
				mode = pms_pkg::MODE_BAD;
		end else if (param_select_field == pms_pkg::PARAM_NONE) begin // R18
			mode = pms_pkg::MODE_IDLE;
		end else begin
			mode = pms_pkg::MODE_KEYING;
		end
	end

	// Pin decode; unsupported combinations hold profile 0 and flag an error
	always_comb begin
		idx_next = pms_pkg::PROFILE_RESET;
		ramp_en_next = 1'b0;
		ramp_dn_next = 1'b0;
		bad_next = 1'b0;
		case (amplitude_ramp_field)
			pms_pkg::RAMP_OFF: begin
				case (level_field) // R1
					pms_pkg::LEVEL_2: idx_next = {3'h0, p[1]}; // R2
					pms_pkg::LEVEL_4: begin
						if (pin_config_field == pms_pkg::PINCFG_011)
							idx_next = {2'h0, p[1:0]}; // R3
						else
							bad_next = 1'b1;
					end
					pms_pkg::LEVEL_8: begin
						if (cfg_x01(pin_config_field))
							idx_next = {1'b0, p[2:0]}; // R4
						else
							bad_next = 1'b1;
					end
					default: begin
						if (cfg_x01(pin_config_field))
							idx_next = p; // R5
						else
							bad_next = 1'b1;
					end
				endcase
			end
			pms_pkg::RAMP_P23: begin
				ramp_en_next = 1'b1;
				if (level_field != pms_pkg::LEVEL_2)
					bad_next = 1'b1; // R6
				else if (pin_config_field == pms_pkg::PINCFG_000) begin
					idx_next = {3'h0, p[1]}; // R6
					ramp_dn_next = p[3]; // R17
				end else if (pin_config_field == pms_pkg::PINCFG_011) begin
					idx_next = {3'h0, p[0]}; // R6
					ramp_dn_next = p[2]; // R17
				end else
					bad_next = 1'b1;
			end
			pms_pkg::RAMP_P3: begin
				ramp_en_next = 1'b1;
				ramp_dn_next = p[3]; // R7 R17
				if (level_field == pms_pkg::LEVEL_8 &&
					cfg_x01(pin_config_field))
					idx_next = {1'b0, p[2:0]}; // R7
				else
					bad_next = 1'b1;
			end
			default: begin
				ramp_en_next = 1'b1; // R8
				case (level_field)
					pms_pkg::LEVEL_2: begin
						idx_next = {3'h0, p[1]};
						// Serial 1 is ignored; serial 2 or 3 high requests ramp-down
						ramp_dn_next = pins[5] | pins[6]; // R8
					end
					pms_pkg::LEVEL_4: begin
						if (pin_config_field == pms_pkg::PINCFG_000) begin
							idx_next = {2'h0, p[3:2]}; // R9
							ramp_dn_next = pins[5]; // R9
						end else if (pin_config_field ==
							pms_pkg::PINCFG_011) begin
							idx_next = {2'h0, p[1:0]}; // R9
							ramp_dn_next = pins[4]; // R9
						end else
							bad_next = 1'b1;
					end
					pms_pkg::LEVEL_16: begin
						if (cfg_x01(pin_config_field)) begin
							idx_next = p; // R10
							ramp_dn_next = pins[4]; // R10
						end else
							bad_next = 1'b1;
					end
					default: bad_next = 1'b1; // R8
				endcase
			end
		endcase
		// Sweep overrides keying: only pin 1 matters, level 00 required
		if (mode == pms_pkg::MODE_SWEEP)
			idx_next = {3'h0, p[1]}; // R13
		if (mode == pms_pkg::MODE_BAD)
			bad_next = 1'b1; // R14
		// Refused combinations must not leak a pin-chosen profile
		if (bad_next)
			idx_next = pms_pkg::PROFILE_RESET; // R1
	end

	// Selected profile updates one cycle after the synchronised pins
	always_ff @(posedge clk) begin
		if (!resetn) begin
			profile_index <= pms_pkg::PROFILE_RESET;
			profile_addr <= pms_pkg::ADDR_RESET;
			modulation_active <= 1'b0;
			config_error <= 1'b0;
		end else begin
			profile_index <= idx_next; // R19
			profile_addr <= addr_of(idx_next); // R2 R3 R4 R5 R10
			modulation_active <= (mode == pms_pkg::MODE_KEYING) && !bad_next;
			config_error <= bad_next;
		end
	end

	// Amplitude ramp requests via the 10-bit scaler
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ramp_enable <= 1'b0;
			ramp_down <= 1'b0;
			serial_single_bit <= 1'b0;
		end else begin
			ramp_enable <= ramp_en_next && !bad_next; // R16
			ramp_down <= ramp_dn_next; // R17
			serial_single_bit <=
				(amplitude_ramp_field == pms_pkg::RAMP_SERIAL); // R8
		end
	end

	// Sweep: pin 1 rising starts up, falling starts down
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sweep_active <= 1'b0;
			sweep_up <= 1'b0;
			sweep_start <= 1'b0;
			pin1_last_reg <= 1'b0;
			sweep_start_addr <= pms_pkg::ADDR_FREQ0;
			sweep_end_addr <= pms_pkg::ADDR_PROFILE1;
			sweep_end_bits <= 6'(pms_pkg::FREQ_BITS);
		end else begin
			pin1_last_reg <= p[1];
			sweep_active <= (mode == pms_pkg::MODE_SWEEP);
			sweep_up <= p[1]; // R13
			sweep_start <= (mode == pms_pkg::MODE_SWEEP) &&
				(p[1] != pin1_last_reg); // R13
			sweep_end_addr <= pms_pkg::ADDR_PROFILE1; // R11
			case (param_select_field)
				pms_pkg::PARAM_AMPL: begin
					sweep_start_addr <= pms_pkg::ADDR_AMPL0; // R11
					sweep_end_bits <= 6'(pms_pkg::AMPL_BITS); // R12
				end
				pms_pkg::PARAM_PHASE: begin
					sweep_start_addr <= pms_pkg::ADDR_PHASE0; // R11
					sweep_end_bits <= 6'(pms_pkg::PHASE_BITS); // R12
				end
				default: begin
					sweep_start_addr <= pms_pkg::ADDR_FREQ0; // R11
					sweep_end_bits <= 6'(pms_pkg::FREQ_BITS); // R12
				end
			endcase
		end
	end
endmodule

// file: sim/pms_ctrl_model.sv
`timescale 1ns/1ps
module pms_ctrl_model (
	// Clock
	input wire logic clk,
	// Requested levels {s3,s2,s1,p3,p2,p1,p0}
	input wire logic [6:0] want,
	// Pins
	output logic [6:0] pins = 7'h00
);
	// Serial pins carry ramp levels only, never port data
	always @(negedge clk) begin
		pins <= want;
	end
endmodule

// file: sim/pms_properties.sv
`timescale 1ns/1ps
module pms_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration
	input wire logic [1:0] param_select_field,
	input wire logic [1:0] level_field,
	input wire logic [1:0] amplitude_ramp_field,
	// Pins
	input wire logic profile_pin_0,
	input wire logic profile_pin_1,
	input wire logic profile_pin_2,
	input wire logic profile_pin_3,
	// Outputs
	input wire logic [3:0] profile_index,
	input wire logic [7:0] profile_addr,
	input wire logic modulation_active,
	input wire logic config_error,
	input wire logic serial_single_bit,
	input wire logic sweep_active,
	input wire logic sweep_up,
	input wire logic sweep_start,
	input wire logic [7:0] sweep_end_addr,
	input wire logic [5:0] sweep_end_bits,
	input wire logic ramp_enable,
	input wire logic ramp_down
);
	// Past pin values are meaningless until the sync chain refilled
	logic [2:0] live_cnt;
	always_ff @(posedge clk) begin
		if (!resetn)
			live_cnt <= 3'h0;
		else if (live_cnt != 3'h4)
			live_cnt <= live_cnt + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_sweep_two;
		sweep_active [*2];
	endsequence
	AST_END_ADDR: assert property (sweep_end_addr == 8'h0a)
		else $error("sweep end address wrong");
	AST_ADDR: assert property (profile_addr == (profile_index == 4'h0 ?
		8'h04 : 8'h09 + {4'h0, profile_index})) else $error("addr mismatch");
	AST_REFUSE: assert property (config_error |->
		profile_index == 4'h0 && !ramp_enable) else $error("bad refusal");
	AST_SERIAL: assert property (live_cnt == 3'h4 |-> serial_single_bit ==
		($past(amplitude_ramp_field) == 2'h3)) else $error("serial mode");
	AST_BITS: assert property (live_cnt == 3'h4 && sweep_active &&
		$past(param_select_field) == 2'h3 |-> sweep_end_bits == 6'h0e)
		else $error("phase end bits wrong");
	AST_UP: assert property (live_cnt == 3'h4 ##0 s_sweep_two |->
		sweep_up == $past(profile_pin_1, 3)) else $error("sweep dir");
	AST_START: assert property (live_cnt == 3'h4 && sweep_start |->
		$past(profile_pin_1, 3) != $past(profile_pin_1, 4))
		else $error("start without edge");
	AST_RAMP: assert property (live_cnt == 3'h4 && ramp_enable &&
		$past(amplitude_ramp_field) == 2'h2 |->
		ramp_down == $past(profile_pin_3, 3)) else $error("ramp level");
	AST_LEVEL8: assert property (live_cnt == 3'h4 && modulation_active &&
		$past(level_field) == 2'h2 |-> profile_index == {1'b0,
		$past(profile_pin_2, 3), $past(profile_pin_1, 3),
		$past(profile_pin_0, 3)}) else $error("eight level index");
endmodule
bind pms_profile_select pms_properties chk_i (.*);

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [1:0] param_select_field = 2'h0;
	logic [1:0] level_field = 2'h0;
	logic [1:0] amplitude_ramp_field = 2'h0;
	logic [2:0] pin_config_field = 3'h0;
	logic sweep_enable = 1'b0;
	logic [6:0] want = 7'h00;
	wire logic profile_pin_0, profile_pin_1, profile_pin_2, profile_pin_3;
	wire logic serial_pin_1, serial_pin_2, serial_pin_3;
	logic [3:0] profile_index;
	logic [7:0] profile_addr, sweep_start_addr, sweep_end_addr;
	logic [5:0] sweep_end_bits;
	logic modulation_active, config_error, serial_single_bit, sweep_active;
	logic sweep_up, sweep_start, ramp_enable, ramp_down;
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_start = 0;
	always #2 clk = ~clk;
	pms_ctrl_model far (.clk(clk), .want(want), .pins({serial_pin_3,
		serial_pin_2, serial_pin_1, profile_pin_3, profile_pin_2,
		profile_pin_1, profile_pin_0}));
	pms_profile_select uut (.*);
	task close_out;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Pins reach the model one negedge late, then three sync edges
	task set(input logic [1:0] p, input logic [1:0] l, input logic [1:0] r,
		input logic [2:0] c, input logic s, input logic [6:0] w);
		param_select_field <= p;
		level_field <= l;
		amplitude_ramp_field <= r;
		pin_config_field <= c;
		sweep_enable <= s;
		want <= w;
		repeat (6) @(negedge clk);
	endtask
	task pick(input logic [3:0] i, input logic [7:0] a);
		chk("index", {4'h0, profile_index}, {4'h0, i});
		chk("addr", profile_addr, a);
	endtask
	task t_level2;
		set(2'h2, 2'h0, 2'h0, 3'h5, 1'b0, 7'h0d);
		pick(4'h0, 8'h04);
		set(2'h2, 2'h0, 2'h0, 3'h6, 1'b0, 7'h02);
		pick(4'h1, 8'h0a);
		chk("mod", {7'h0, modulation_active}, 8'h01);
	endtask
	task t_level4;
		set(2'h3, 2'h1, 2'h0, 3'h3, 1'b0, 7'h03);
		pick(4'h3, 8'h0c);
	endtask
	task t_level8;
		set(2'h1, 2'h2, 2'h0, 3'h5, 1'b0, 7'h0f);
		pick(4'h7, 8'h10);
	endtask
	task t_level16;
		set(2'h2, 2'h3, 2'h0, 3'h1, 1'b0, 7'h0e);
		pick(4'he, 8'h17);
	endtask
	task t_ramp01;
		set(2'h2, 2'h0, 2'h1, 3'h0, 1'b0, 7'h0a);
		pick(4'h1, 8'h0a);
		chk("down", {7'h0, ramp_down}, 8'h01);
		set(2'h2, 2'h0, 2'h1, 3'h3, 1'b0, 7'h0a);
		pick(4'h0, 8'h04);
		chk("down", {7'h0, ramp_down}, 8'h00);
	endtask
	task t_ramp10;
		set(2'h2, 2'h2, 2'h2, 3'h1, 1'b0, 7'h0d);
		pick(4'h5, 8'h0e);
		chk("ramp", {7'h0, ramp_enable}, 8'h01);
		chk("down", {7'h0, ramp_down}, 8'h01);
	endtask
	task t_serial4;
		set(2'h2, 2'h1, 2'h3, 3'h0, 1'b0, 7'h27);
		pick(4'h1, 8'h0a);
		chk("down", {7'h0, ramp_down}, 8'h01);
		chk("single", {7'h0, serial_single_bit}, 8'h01);
	endtask
	task t_serial16;
		set(2'h2, 2'h3, 2'h3, 3'h1, 1'b0, 7'h1d);
		pick(4'hd, 8'h16);
		chk("down", {7'h0, ramp_down}, 8'h01);
	endtask
	task t_sweep;
		for (int k = 1; k < 4; k++) begin
			set(2'(k), 2'h0, 2'h0, 3'h0, 1'b1, 7'h02);
			chk("active", {7'h0, sweep_active}, 8'h01);
			chk("start", sweep_start_addr, k == 1 ? 8'h06 :
				k == 2 ? 8'h04 : 8'h05);
			chk("bits", {2'h0, sweep_end_bits}, k == 1 ? 8'h0a :
				k == 2 ? 8'h20 : 8'h0e);
			chk("up", {7'h0, sweep_up}, 8'h01);
		end
		set(2'h2, 2'h0, 2'h0, 3'h0, 1'b1, 7'h00);
		chk("up", {7'h0, sweep_up}, 8'h00);
		chk("end", sweep_end_addr, 8'h0a);
		n_start = 0;
		want <= 7'h02;
		repeat (8) begin
			@(negedge clk);
			if (sweep_start === 1'b1)
				n_start++;
		end
		chk("pulses", n_start[7:0], 8'h01);
		chk("up", {7'h0, sweep_up}, 8'h01);
	endtask
	task t_bad;
		set(2'h2, 2'h1, 2'h1, 3'h0, 1'b0, 7'h0f);
		chk("error", {7'h0, config_error}, 8'h01);
		chk("ramp", {7'h0, ramp_enable}, 8'h00);
		set(2'h0, 2'h0, 2'h0, 3'h0, 1'b1, 7'h02);
		chk("error", {7'h0, config_error}, 8'h01);
		chk("index", {4'h0, profile_index}, 8'h00);
		set(2'h0, 2'h0, 2'h0, 3'h0, 1'b0, 7'h02);
		chk("mod", {7'h0, modulation_active}, 8'h00);
		chk("error", {7'h0, config_error}, 8'h00);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			close_out;
		end
	end
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		t_level2;
		t_level4;
		t_level8;
		t_level16;
		t_ramp01;
		t_ramp10;
		t_serial4;
		t_serial16;
		t_sweep;
		t_bad;
		close_out;
	end
endmodule
